// file: design/acl_pkg.sv
// Constants shared by the second-stage access-control key and action logic.
package acl_pkg;
  // Register byte offsets on the APB side.
  localparam logic [7:0] ACL_REG_CTRL = 8'h00;
  localparam logic [7:0] ACL_REG_ARM = 8'h04;
  localparam logic [7:0] ACL_REG_HITS = 8'h08;
  localparam logic [7:0] ACL_REG_LAST = 8'h0c;
  // Reset values.
  localparam logic [31:0] ACL_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] ACL_HITS_RESET = 32'h0000_0000;
  // Frame layout constants, in bytes, and the OAM frame type word value.
  localparam int ACL_IPV4_HDR_BYTES = 20;
  localparam int ACL_IPV6_HDR_BYTES = 40;
  localparam int ACL_MAC_PAIR_BYTES = 12;
  localparam int ACL_VLAN_TAG_BYTES = 4;
  localparam int ACL_FRAME_TYPE_WORD_BYTES = 2;
  localparam logic [15:0] ACL_OAM_FRAME_TYPE_WORD = 16'h8902;
  // Key field widths in bytes.
  localparam int ACL_IP_PAY_BYTES = 12;
  localparam int ACL_L4_PAY_BYTES = 8;
  localparam int ACL_WIDE_BYTES = 57;
  localparam int ACL_NARROW_BYTES = 24;
  // Action word layout, packed upward from bit 0.
  localparam int ACL_ACT_WIDTH = 196;
  localparam int ACL_F_INNER = 0;
  localparam int ACL_F_FORCE = 1;
  localparam int ACL_F_POINT = 2;
  localparam int ACL_F_ONCE = 7;
  localparam int ACL_F_INTR = 8;
  localparam int ACL_F_COPY = 9;
  localparam int ACL_F_QUEUE = 10;
  localparam int ACL_F_CPUDIS = 13;
  localparam int ACL_F_LRNDIS = 14;
  localparam int ACL_F_RTDIS = 15;
  localparam int ACL_F_POLICE = 16;
  localparam int ACL_F_PIDX = 17;
  localparam int ACL_F_IGNORE = 22;
  localparam int ACL_F_USED = 23;
  // Pipeline points and action kinds.
  localparam logic [4:0] ACL_PT_NONE = 5'h00;
  localparam logic [4:0] ACL_PT_INNER_SW = 5'h0d;
  localparam logic [4:0] ACL_PT_DONE = 5'h10;
  localparam logic [1:0] ACL_KIND_NONE = 2'h0;
endpackage

// file: design/acl_key_action.sv
// Second-stage lookup key tail builder and action decoder with APB registers.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps

// Behaviour
// R01: IP payload key field is 96 bits, IPv4 taken 20 bytes past header.
// R02: Transport payload field holds 64 bits following the TCP_OR_UDP_FLAG header.
// R03: Non TCP_OR_UDP_FLAG frames fill transport field with IP payload bytes 0-7.
// R04: Loss counter flag set when all three CCM counters are zero.
// R05: OAM flag when EtherType is 0x8902; type word then carries MEL flags.
// R06: Wide custom field is 57 bytes from the current frame pointer.
// R07: Ethernet frames start custom payload after MACs, 0-3 tags, EtherType.
// R08: Narrow custom field is 24 bytes at a pointer set earlier.
// R09: One 196-bit action format serves every key type.
// R10: Software packs action fields in order, first field at bit 0.
// R11: Inner flag marks the action as belonging to the inner switch point.
// R12: Forcing applies the point outright; point NONE gives action kind NONE.
// R13: Point selector is 5 bits, values 0 (NONE) to 16 (DONE).
// R14: Single-hit copy sends the next hitting frame to the chosen CPU queue.
// R15: Copy-always copies every hit and overrides single-hit copy.
// R16: Interrupt enable raises an interrupt on each hit of the rule.
// R17: Three-bit queue selector picks the CPU queue for copies.
// R18: Extraction block cancels earlier CPU extraction; copy still applies after.
// R19: Learning block forbids learning; routing block forbids routing.
// R20: Policer apply polices with the 5-bit policer index.
// R21: Without policing, the index selects the swap source IP entry.
// R22: Pipeline override applies the action even to a terminated frame.
// R23: After its single copy, a rule copies no more until re-armed.
module acl_key_action import acl_pkg::*; #(
  parameter int WIN_BYTES = 128,
  parameter int RULES = 16,
  parameter int OFS_W = 7,
  parameter int RULE_W = 4
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_frame_valid,
  input wire logic [8*WIN_BYTES-1:0] i_frame_window,
  input wire logic i_is_eth_frame,
  input wire logic i_is_ipv4,
  input wire logic [1:0] i_vlan_tags,
  input wire logic [OFS_W-1:0] i_ip_hdr_start,
  input wire logic [OFS_W-1:0] i_transport_payload_bytes_start,
  input wire logic [OFS_W-1:0] i_frame_pointer,
  input wire logic [OFS_W-1:0] i_narrow_pointer,
  input wire logic i_tcp_or_udp_flag,
  input wire logic i_tcp_ack,
  input wire logic i_tcp_urg,
  input wire logic [15:0] i_ethertype,
  input wire logic [15:0] i_oam_level_flags,
  input wire logic [31:0] i_ccm_tx_fwd,
  input wire logic [31:0] i_ccm_rx_back,
  input wire logic [31:0] i_ccm_tx_back,
  output logic o_key_valid,
  output logic o_tcp_ack_flag,
  output logic o_tcp_urgent_flag,
  output logic [95:0] o_ip_payload_bytes,
  output logic [63:0] o_transport_payload_bytes,
  output logic o_ccm_loss_counters_zero,
  output logic o_oam_frame_flag,
  output logic [15:0] o_frame_type_word,
  output logic [455:0] o_wide_custom_payload,
  output logic [191:0] o_narrow_custom_payload,
  input wire logic i_hit,
  input wire logic [RULE_W-1:0] i_rule_index,
  input wire logic [ACL_ACT_WIDTH-1:0] i_action,
  input wire logic i_terminated,
  input wire logic [4:0] i_prev_point,
  input wire logic [1:0] i_prev_kind,
  input wire logic [7:0] i_prev_cpu_queues,
  output logic o_act_valid,
  output logic o_inner_stage_flag,
  output logic [4:0] o_pipeline_point,
  output logic [1:0] o_pipeline_action_kind,
  output logic [7:0] o_cpu_queues,
  output logic o_cpu_copy,
  output logic o_hit_irq,
  output logic o_learning_block,
  output logic o_routing_block,
  output logic o_policer_apply,
  output logic [4:0] o_policer_index,
  output logic o_swap_source_ip_table_valid,
  output logic [4:0] o_swap_source_ip_table_index
);

  // Pull WIDE_BYTES bytes from the window starting at a byte offset.
  // Bytes beyond the window read as zero rather than wrapping round.
  function automatic logic [8*ACL_WIDE_BYTES-1:0] grab(
    input logic [8*WIN_BYTES-1:0] win,
    input logic [OFS_W+1:0] start
  );
    logic [8*ACL_WIDE_BYTES-1:0] res;
    int idx;
    res = '0;
    for (int k = 0; k < ACL_WIDE_BYTES; k++) begin
      idx = int'(start) + k;
      if (idx < WIN_BYTES) begin
        res[8*k +: 8] = win[8*idx +: 8];
      end
    end
    return res;
  endfunction

  // Byte offsets of each key window.
  localparam logic [OFS_W+1:0] V4_HDR = (OFS_W+2)'(ACL_IPV4_HDR_BYTES);
  localparam logic [OFS_W+1:0] V6_HDR = (OFS_W+2)'(ACL_IPV6_HDR_BYTES);
  localparam logic [OFS_W+1:0] MACS = (OFS_W+2)'(ACL_MAC_PAIR_BYTES);
  localparam logic [OFS_W+1:0] TAG = (OFS_W+2)'(ACL_VLAN_TAG_BYTES);
  localparam logic [OFS_W+1:0] ETYP = (OFS_W+2)'(ACL_FRAME_TYPE_WORD_BYTES);
  wire logic [OFS_W+1:0] ip_hdr_len = i_is_ipv4 ? V4_HDR : V6_HDR; // R01
  wire logic [OFS_W+1:0] ip_pay_start =
    {2'b00, i_ip_hdr_start} + ip_hdr_len; // R01
  wire logic [OFS_W+1:0] l4_start = i_tcp_or_udp_flag ?
    {2'b00, i_transport_payload_bytes_start} : ip_pay_start; // R02 R03
  wire logic [OFS_W+1:0] eth_end =
    MACS + TAG * {{OFS_W{1'b0}}, i_vlan_tags} + ETYP; // R07
  wire logic [OFS_W+1:0] wide_start =
    i_is_eth_frame ? eth_end : {2'b00, i_frame_pointer}; // R06 R07
  wire logic [OFS_W+1:0] narrow_start =
    i_is_eth_frame ? eth_end : {2'b00, i_narrow_pointer}; // R08 R07
  wire logic [8*ACL_WIDE_BYTES-1:0] ip_bytes = grab(i_frame_window,
    ip_pay_start);
  wire logic [8*ACL_WIDE_BYTES-1:0] l4_bytes = grab(i_frame_window,
    l4_start);
  wire logic [8*ACL_WIDE_BYTES-1:0] wide_bytes = grab(i_frame_window,
    wide_start);
  wire logic [8*ACL_WIDE_BYTES-1:0] narrow_bytes = grab(i_frame_window,
    narrow_start);
  wire logic ccm_zero = (i_ccm_tx_fwd == 32'h0) &&
    (i_ccm_rx_back == 32'h0) && (i_ccm_tx_back == 32'h0); // R04
  wire logic is_oam = (i_ethertype == ACL_OAM_FRAME_TYPE_WORD); // R05
  wire logic [15:0] type_word = is_oam ? i_oam_level_flags : i_ethertype;

  // Key register; every key field lands one cycle after the frame strobe.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_key_valid <= 1'b0;
      o_tcp_ack_flag <= 1'b0;
      o_tcp_urgent_flag <= 1'b0;
      o_ip_payload_bytes <= '0;
      o_transport_payload_bytes <= '0;
      o_ccm_loss_counters_zero <= 1'b0;
      o_oam_frame_flag <= 1'b0;
      o_frame_type_word <= 16'h0000;
      o_wide_custom_payload <= '0;
      o_narrow_custom_payload <= '0;
    end else begin
      o_key_valid <= i_frame_valid;
      if (i_frame_valid) begin
        o_tcp_ack_flag <= i_tcp_ack;
        o_tcp_urgent_flag <= i_tcp_urg;
        o_ip_payload_bytes <= ip_bytes[8*ACL_IP_PAY_BYTES-1:0]; // R01
        o_transport_payload_bytes <= l4_bytes[8*ACL_L4_PAY_BYTES-1:0];
        o_ccm_loss_counters_zero <= ccm_zero; // R04
        o_oam_frame_flag <= is_oam; // R05
        o_frame_type_word <= type_word; // R05
        o_wide_custom_payload <= wide_bytes; // R06
        o_narrow_custom_payload <=
          narrow_bytes[8*ACL_NARROW_BYTES-1:0]; // R08
      end
    end
  end

  // Action field split; one layout for every key type, bit 0 first.
  wire logic a_inner = i_action[ACL_F_INNER]; // R09 R10
  wire logic a_force = i_action[ACL_F_FORCE];
  wire logic [4:0] a_point = i_action[ACL_F_POINT +: 5];
  wire logic a_once = i_action[ACL_F_ONCE];
  wire logic a_intr = i_action[ACL_F_INTR];
  wire logic a_copy = i_action[ACL_F_COPY];
  wire logic [2:0] a_queue = i_action[ACL_F_QUEUE +: 3];
  wire logic a_cpudis = i_action[ACL_F_CPUDIS];
  wire logic a_lrndis = i_action[ACL_F_LRNDIS];
  wire logic a_rtdis = i_action[ACL_F_RTDIS];
  wire logic a_police = i_action[ACL_F_POLICE];
  wire logic [4:0] a_pidx = i_action[ACL_F_PIDX +: 5];
  wire logic a_ignore = i_action[ACL_F_IGNORE];

  // Software state reached over APB.
  logic enable;
  logic [RULES-1:0] armed;
  logic [31:0] hits;
  logic [ACL_F_USED-1:0] last_action;

  // A hit is acted on only when enabled and the frame is still live,
  // unless the action overrides an earlier termination.
  wire logic apply = i_hit && enable && (!i_terminated || a_ignore); // R22
  wire logic point_legal = (a_point <= ACL_PT_DONE); // R13
  // Illegal point codes above DONE are treated as no forcing at all.
  wire logic do_force = a_force && point_legal; // R12 R13
  wire logic [4:0] next_point = do_force ? a_point : i_prev_point; // R12
  wire logic [1:0] next_kind = (do_force && a_point == ACL_PT_NONE) ?
    ACL_KIND_NONE : i_prev_kind; // R12
  wire logic once_copy = a_once && armed[i_rule_index]; // R14 R23
  wire logic copy_now = a_copy || once_copy; // R15 R14
  wire logic [7:0] queue_bit = 8'h01 << a_queue; // R17
  // Block first, then the copy, so a copy survives its own block.
  wire logic [7:0] base_queues = a_cpudis ? 8'h00 : i_prev_cpu_queues;
  wire logic [7:0] next_queues =
    base_queues | (copy_now ? queue_bit : 8'h00); // R18
  wire logic consume = apply && a_once && !a_copy && armed[i_rule_index];
  // One-hot mask of the rule whose single copy is now spent.
  wire logic [RULES-1:0] clear_arm =
    consume ? RULES'(1) << i_rule_index : '0; // R23

  // Decoded action register, one cycle behind the hit strobe.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_act_valid <= 1'b0;
      o_inner_stage_flag <= 1'b0;
      o_pipeline_point <= ACL_PT_NONE;
      o_pipeline_action_kind <= ACL_KIND_NONE;
      o_cpu_queues <= 8'h00;
      o_cpu_copy <= 1'b0;
      o_hit_irq <= 1'b0;
      o_learning_block <= 1'b0;
      o_routing_block <= 1'b0;
      o_policer_apply <= 1'b0;
      o_policer_index <= 5'h00;
      o_swap_source_ip_table_valid <= 1'b0;
      o_swap_source_ip_table_index <= 5'h00;
    end else begin
      o_act_valid <= apply;
      o_hit_irq <= apply && a_intr; // R16
      if (apply) begin
        o_inner_stage_flag <= a_inner; // R11
        o_pipeline_point <= next_point; // R12
        o_pipeline_action_kind <= next_kind; // R12
        o_cpu_queues <= next_queues; // R18
        o_cpu_copy <= copy_now; // R14 R15
        o_learning_block <= a_lrndis; // R19
        o_routing_block <= a_rtdis; // R19
        o_policer_apply <= a_police; // R20
        o_policer_index <= a_police ? a_pidx : 5'h00; // R20
        o_swap_source_ip_table_valid <= !a_police; // R21
        o_swap_source_ip_table_index <= a_police ? 5'h00 : a_pidx; // R21
      end
    end
  end

  // APB decode; the slave never waits and flags unmapped addresses.
  wire logic acc = i_psel && i_penable;
  wire logic hit_ctrl = (i_paddr == ACL_REG_CTRL);
  wire logic hit_arm = (i_paddr == ACL_REG_ARM);
  wire logic hit_hits = (i_paddr == ACL_REG_HITS);
  wire logic hit_last = (i_paddr == ACL_REG_LAST);
  wire logic mapped = hit_ctrl || hit_arm || hit_hits || hit_last;
  wire logic wr = acc && i_pwrite && mapped;
  wire logic [RULES-1:0] rearm = (wr && hit_arm) ?
    i_pwdata[RULES-1:0] : '0;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;
  assign o_prdata = !acc || i_pwrite ? 32'h0 :
    hit_ctrl ? {31'h0, enable} :
    hit_arm ? 32'(armed) :
    hit_hits ? hits :
    hit_last ? {{(32-ACL_F_USED){1'b0}}, last_action} : 32'h0;

  // Writing CTRL steers the block; writing 1s to ARM re-arms rules.
  // A re-arm landing with the consuming hit wins, so it is never lost.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      enable <= ACL_CTRL_RESET[0];
      armed <= '1;
      hits <= ACL_HITS_RESET;
      last_action <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        enable <= i_pwdata[0];
      end
      armed <= (armed & ~clear_arm) | rearm; // R23
      if (wr && hit_hits) begin
        hits <= ACL_HITS_RESET;
      end else if (apply) begin
        hits <= hits + 32'h1;
      end
      if (apply) begin
        last_action <= i_action[ACL_F_USED-1:0];
      end
    end
  end

  // Checks on the action and key paths.
  oam_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_frame_valid |=> o_oam_frame_flag == ($past(i_ethertype) ==
    ACL_OAM_FRAME_TYPE_WORD)) // R05
    else $error("OAM flag does not follow the EtherType.");
  ccm_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_frame_valid && i_ccm_tx_fwd != 32'h0 |=>
    !o_ccm_loss_counters_zero) // R04
    else $error("Loss counter flag set with a nonzero counter.");
  ip_pay_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_frame_valid && i_is_ipv4 && i_ip_hdr_start == '0 |=>
    o_ip_payload_bytes[7:0] == $past(i_frame_window[8*20 +: 8])) // R01
    else $error("IPv4 payload not taken 20 bytes after the header.");
  force_none_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    apply && a_force && a_point == ACL_PT_NONE |=>
    o_pipeline_action_kind == ACL_KIND_NONE &&
    o_pipeline_point == ACL_PT_NONE) // R12
    else $error("Forced NONE point left an action kind.");
  copy_wins_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    apply && a_copy && a_cpudis |=>
    o_cpu_copy && o_cpu_queues == $past(queue_bit)) // R18
    else $error("Copy request lost under extraction block.");
  once_only_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    consume && rearm[i_rule_index] == 1'b0 ##1
    apply && a_once && !a_copy && $past(i_rule_index) == i_rule_index
    && rearm == '0 |=> !o_cpu_copy) // R23
    else $error("Second single-hit copy without re-arm.");
  irq_hit_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_hit_irq |-> $past(apply) && $past(a_intr)) // R16
    else $error("Interrupt without an enabled hit.");
  terminated_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_hit && i_terminated && !a_ignore |=> !o_act_valid) // R22
    else $error("Action applied to a terminated frame.");
  police_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply |=> o_policer_apply != o_swap_source_ip_table_valid) // R20 R21
    else $error("Policer index meaning not exclusive.");
  inner_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply |=> o_inner_stage_flag == $past(i_action[ACL_F_INNER])) // R11
    else $error("Inner stage flag not taken from bit 0.");

  // Checks on copy, queue, block, policer, point and custom payload decoding; a slip in any field
  // offset would otherwise surface only as a rare random mismatch.
  copy_always_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    apply && a_copy |=> o_cpu_copy) // R15
    else $error("Copy-always hit did not copy.");
  once_copy_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply && a_once && armed[i_rule_index] |=> o_cpu_copy) // R14
    else $error("Armed single-hit rule did not copy.");
  queue_sel_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply && a_copy |=> o_cpu_queues[$past(a_queue)]) // R17
    else $error("Copied frame missing its CPU queue.");
  block_bits_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply |=> o_learning_block == $past(a_lrndis) &&
    o_routing_block == $past(a_rtdis)) // R19
    else $error("Learning or routing block not taken from the action.");
  policer_index_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply && a_police |=> o_policer_apply &&
    o_policer_index == $past(a_pidx)) // R20
    else $error("Policer index not passed through.");
  swap_idx_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply && !a_police |=> o_swap_source_ip_table_valid &&
    o_swap_source_ip_table_index == $past(a_pidx)) // R21
    else $error("Swap source index not passed through.");
  bad_point_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    apply && a_point > ACL_PT_DONE |=>
    o_pipeline_point == $past(i_prev_point)) // R13
    else $error("Illegal point code was applied.");
  eth_start_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_frame_valid && i_is_eth_frame && i_vlan_tags == 2'h0 |=>
    o_wide_custom_payload[7:0] == $past(i_frame_window[8*14 +: 8])) // R07
    else $error("Custom payload not taken after the Ethernet layer.");
  forced_point_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    apply && a_force && a_point <= ACL_PT_DONE |=>
    o_pipeline_point == $past(a_point)) // R12
    else $error("Forced pipeline point not applied.");

endmodule

// file: tb/acl_far_model.sv
// Far-side parser model that supplies the frame byte window.
`timescale 1ns/10ps
module acl_far_model #(
  parameter int BYTES = 128
) (
  input wire logic i_clock,
  input wire logic i_advance,
  output logic [8*BYTES-1:0] o_window
);
  logic [15:0] state;

  // Start from a known window so the design never sees unknown bytes.
  initial begin
    state = 16'h1234;
    o_window = '0;
  end

  // A new window appears only on request, so it stands while sampled.
  always @(posedge i_clock) begin
    if (i_advance) begin
      state <= state * 16'h6255 + 16'h3619;
      for (int n = 0; n < BYTES; n++) begin
        o_window[8*n +: 8] <= state[7:0] ^ (state[15:8] + 8'(n));
      end
    end
  end
endmodule

// file: tb/acl_stage2_key_action_test.sv
// Self-checking bench for the key tail builder and action decoder.
`timescale 1ns/10ps
module acl_stage2_key_action_test import acl_pkg::*; ;
  int seed = 13;
  int errors = 0;
  int checks_done = 0;
  int hits = 0;
  logic en;
  logic adv;
  logic [15:0] armed;
  logic [22:0] last;
  logic [827:0] kq[$];
  logic [31:0] aq[$];
  logic i_clock, i_sys_rst, i_psel, i_penable, i_pwrite, i_frame_valid;
  logic o_pready, o_pslverr, i_is_eth_frame, i_is_ipv4, i_tcp_or_udp_flag;
  logic i_tcp_ack, i_tcp_urg, o_key_valid, o_tcp_ack_flag, o_tcp_urgent_flag;
  logic o_ccm_loss_counters_zero, o_oam_frame_flag, i_hit, i_terminated;
  logic o_act_valid, o_inner_stage_flag, o_cpu_copy, o_hit_irq;
  logic o_learning_block, o_routing_block, o_policer_apply, o_swap_source_ip_table_valid;
  logic [7:0] i_paddr, i_prev_cpu_queues, o_cpu_queues;
  logic [31:0] i_pwdata, o_prdata, i_ccm_tx_fwd, i_ccm_rx_back, i_ccm_tx_back;
  logic [1023:0] i_frame_window;
  logic [1:0] i_vlan_tags, i_prev_kind, o_pipeline_action_kind;
  logic [6:0] i_ip_hdr_start, i_transport_payload_bytes_start;
  logic [6:0] i_frame_pointer, i_narrow_pointer;
  logic [15:0] i_ethertype, i_oam_level_flags, o_frame_type_word;
  logic [95:0] o_ip_payload_bytes;
  logic [63:0] o_transport_payload_bytes;
  logic [455:0] o_wide_custom_payload;
  logic [191:0] o_narrow_custom_payload;
  logic [3:0] i_rule_index;
  logic [195:0] i_action;
  logic [4:0] i_prev_point, o_pipeline_point, o_policer_index;
  logic [4:0] o_swap_source_ip_table_index;

  acl_key_action u_acl_key_action (.i_clock, .i_sys_rst, .i_paddr, .i_psel,
    .i_penable, .i_pwrite, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_frame_valid, .i_frame_window, .i_is_eth_frame, .i_is_ipv4,
    .i_vlan_tags, .i_ip_hdr_start, .i_transport_payload_bytes_start, .i_frame_pointer,
    .i_narrow_pointer, .i_tcp_or_udp_flag, .i_tcp_ack, .i_tcp_urg,
    .i_ethertype, .i_oam_level_flags, .i_ccm_tx_fwd, .i_ccm_rx_back,
    .i_ccm_tx_back, .o_key_valid, .o_tcp_ack_flag, .o_tcp_urgent_flag,
    .o_ip_payload_bytes, .o_transport_payload_bytes,
    .o_ccm_loss_counters_zero, .o_oam_frame_flag, .o_frame_type_word,
    .o_wide_custom_payload, .o_narrow_custom_payload, .i_hit, .i_rule_index,
    .i_action, .i_terminated, .i_prev_point, .i_prev_kind,
    .i_prev_cpu_queues, .o_act_valid, .o_inner_stage_flag, .o_pipeline_point,
    .o_pipeline_action_kind, .o_cpu_queues, .o_cpu_copy, .o_hit_irq,
    .o_learning_block, .o_routing_block, .o_policer_apply, .o_policer_index,
    .o_swap_source_ip_table_valid, .o_swap_source_ip_table_index);
  acl_far_model u_acl_far_model (.i_clock, .i_advance(adv),
    .o_window(i_frame_window));

  // Free-running core clock.
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic bad(string m);
    errors++;
    $display("unexpected at %0t ns: %s", $time, m);
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bytes past the end of the window count as zero.
  function automatic logic [455:0] grab(logic [1023:0] w, int s, int n);
    logic [455:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      if (s + i < 128) r[8*i +: 8] = w[8*(s+i) +: 8];
    end
    return r;
  endfunction

  // One APB transfer; the wait is bounded since pready is not assumed.
  task automatic apb(logic [7:0] ad, logic w, logic [31:0] d,
                     logic [31:0] ex, logic er);
    int n;
    n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_paddr <= ad;
    i_pwrite <= w;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    checks_done++;
    if (n >= 50 || o_pslverr !== er || (!w && o_prdata !== ex)) bad("apb");
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // The window is renewed first, then strobed once it has settled.
  task automatic send_frame();
    logic [455:0] t4, t5;
    logic [95:0] ip;
    logic [63:0] l4;
    logic [15:0] et, lv;
    logic [7:0] f;
    logic [2:0] c;
    logic [6:0] ih, ls, fp, np;
    int e;
    @(posedge i_clock);
    adv <= 1'b1;
    @(posedge i_clock);
    adv <= 1'b0;
    @(posedge i_clock);
    f = 8'($random(seed));
    c = 3'($random(seed));
    lv = 16'($random(seed));
    {ih, ls, fp, np} = 28'($random(seed));
    et = f[5] ? ACL_OAM_FRAME_TYPE_WORD : {1'b0, 15'($random(seed))};
    e = ACL_MAC_PAIR_BYTES + ACL_VLAN_TAG_BYTES * f[3:2] + ACL_FRAME_TYPE_WORD_BYTES;
    t4 = grab(i_frame_window, ih + (f[1] ? ACL_IPV4_HDR_BYTES :
              ACL_IPV6_HDR_BYTES), ACL_IP_PAY_BYTES);
    ip = t4[95:0];
    t5 = grab(i_frame_window, ls, ACL_L4_PAY_BYTES);
    l4 = f[4] ? t5[63:0] : ip[63:0];
    t4 = grab(i_frame_window, f[0] ? e : int'(fp), ACL_WIDE_BYTES);
    t5 = grab(i_frame_window, f[0] ? e : int'(np), ACL_NARROW_BYTES);
    kq.push_back({f[6], f[7], ip, l4, c == 3'h0, f[5], f[5] ? lv : et,
                  t4, t5[191:0]});
    i_frame_valid <= 1'b1;
    {i_tcp_urg, i_tcp_ack, i_tcp_or_udp_flag} <= {f[7:6], f[4]};
    {i_vlan_tags, i_is_ipv4, i_is_eth_frame} <= f[3:0];
    {i_ip_hdr_start, i_transport_payload_bytes_start} <= {ih, ls};
    {i_frame_pointer, i_narrow_pointer} <= {fp, np};
    i_ethertype <= et;
    i_oam_level_flags <= lv;
    i_ccm_tx_fwd <= c[0] ? 32'($random(seed)) | 32'h1 : 32'h0;
    i_ccm_rx_back <= c[1] ? 32'($random(seed)) | 32'h1 : 32'h0;
    i_ccm_tx_back <= c[2] ? 32'($random(seed)) | 32'h1 : 32'h0;
    @(posedge i_clock);
    i_frame_valid <= 1'b0;
  endtask

  // Hits go back to back; the caller lowers the strobe after the last one.
  task automatic send_hit();
    logic [223:0] b;
    logic [195:0] a;
    logic cp;
    for (int j = 0; j < 7; j++) b[32*j +: 32] = $random(seed);
    if (b[208:207] == 2'h0) b[6:2] = ACL_PT_NONE;
    a = b[195:0];
    cp = a[9] || (a[7] && armed[b[197:196]]);
    @(posedge i_clock);
    i_hit <= 1'b1;
    i_rule_index <= {2'h0, b[197:196]};
    i_action <= a;
    i_terminated <= b[198] & b[199];
    {i_prev_cpu_queues, i_prev_kind, i_prev_point} <=
      {b[216:209], b[206:205], b[204:200]};
    if (en && !(b[198] & b[199] & !a[22])) begin
      if (a[7] && !a[9]) armed[b[197:196]] = 1'b0;
      hits++;
      last = a[22:0];
      aq.push_back({a[0], (a[1] && a[6:2] <= ACL_PT_DONE) ? a[6:2] :
        b[204:200], (a[1] && a[6:2] == ACL_PT_NONE) ? ACL_KIND_NONE :
        b[206:205], (a[13] ? 8'h0 : b[216:209]) |
        (cp ? 8'h1 << a[12:10] : 8'h0), cp, a[8], a[15:14], a[16],
        a[16] ? a[21:17] : 5'h0, !a[16], a[16] ? 5'h0 : a[21:17]});
    end
  endtask

  // Results are matched in arrival order against the noted expectations.
  always @(posedge i_clock) begin
    if (o_key_valid === 1'b1) begin
      checks_done++;
      if (kq.size() == 0) bad("key without frame");
      else if ({o_tcp_ack_flag, o_tcp_urgent_flag, o_ip_payload_bytes,
        o_transport_payload_bytes, o_ccm_loss_counters_zero, o_oam_frame_flag,
        o_frame_type_word, o_wide_custom_payload, o_narrow_custom_payload}
        !== kq.pop_front()) bad("key fields");
    end
    if (o_act_valid === 1'b1) begin
      checks_done++;
      if (aq.size() == 0) bad("action without hit");
      else if ({o_inner_stage_flag, o_pipeline_point, o_pipeline_action_kind,
        o_cpu_queues, o_cpu_copy, o_hit_irq, o_routing_block,
        o_learning_block, o_policer_apply, o_policer_index, o_swap_source_ip_table_valid,
        o_swap_source_ip_table_index} !== aq.pop_front()) bad("action");
    end
    if (o_hit_irq === 1'b1 && o_act_valid !== 1'b1) bad("stray irq");
  end

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    repeat (5000) @(posedge i_clock);
    errors++;
    print_verdict();
  end

  // Main sequence: registers, frames, then three phases of hits.
  initial begin
    {i_sys_rst, en, armed, last} = {2'h3, 16'hffff, 23'h0};
    {i_psel, i_penable, i_pwrite, i_frame_valid, i_hit, adv} = '0;
    {i_paddr, i_pwdata, i_is_eth_frame, i_is_ipv4, i_vlan_tags} = '0;
    {i_ip_hdr_start, i_transport_payload_bytes_start, i_frame_pointer} = '0;
    {i_narrow_pointer, i_tcp_or_udp_flag, i_tcp_ack, i_tcp_urg} = '0;
    {i_ethertype, i_oam_level_flags, i_ccm_tx_fwd, i_ccm_rx_back} = '0;
    {i_ccm_tx_back, i_rule_index, i_action, i_terminated} = '0;
    {i_prev_point, i_prev_kind, i_prev_cpu_queues} = '0;
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    apb(ACL_REG_CTRL, 1'b0, 32'h0, ACL_CTRL_RESET, 1'b0);
    apb(ACL_REG_HITS, 1'b0, 32'h0, ACL_HITS_RESET, 1'b0);
    apb(ACL_REG_ARM, 1'b0, 32'h0, 32'h0000_ffff, 1'b0);
    apb(8'h40, 1'b1, 32'h1, 32'h0, 1'b1);
    apb(8'h40, 1'b0, 32'h0, 32'h0, 1'b1);
    repeat (40) send_frame();
    for (int p = 0; p < 3; p++) begin
      en = (p != 1);
      apb(ACL_REG_CTRL, 1'b1, {31'h0, en}, 32'h0, 1'b0);
      repeat (60) send_hit();
      @(posedge i_clock);
      i_hit <= 1'b0;
      apb(ACL_REG_HITS, 1'b0, 32'h0, 32'(hits), 1'b0);
      apb(ACL_REG_LAST, 1'b0, 32'h0, {9'h0, last}, 1'b0);
      apb(ACL_REG_ARM, 1'b0, 32'h0, {16'h0, armed}, 1'b0);
      apb(ACL_REG_ARM, 1'b1, 32'h0000_000f, 32'h0, 1'b0);
      armed[3:0] = 4'hf;
      apb(ACL_REG_HITS, 1'b1, 32'h0, 32'h0, 1'b0);
      hits = 0;
    end
    repeat (3) @(posedge i_clock);
    checks_done++;
    if (kq.size() != 0 || aq.size() != 0) bad("result missing");
    print_verdict();
  end
endmodule
